// ===== verilog/adc_sequencer.sv
// Purpose: control, sequencing and result registers of a 10-bit SAR converter
// Assumes: comparator and resistor string sit outside; AXI4-Lite slave
// Notes: one write and one read in flight; answers come one cycle after take
// What this block does
// R1 - ten-bit successive approximation over twelve inputs numbered 0 to 11
// R2 - software turns the reference on and waits 3 us before starting
// R3 - scan bit 0: channel select picks one input 0 to 11
// R4 - scan bit 1: select n converts inputs 0 through n ascending
// R5 - reset clears scan bit and channel select, input 0 fixed
// R6 - writing 1 to the start bit begins a conversion
// R7 - with trigger enabled a falling trigger edge starts; otherwise ignored
// R8 - software avoids select 1011 while the external trigger is enabled
// R9 - busy flag rises when a conversion starts and shows activity
// R10 - completion raises the done interrupt and sets the end flag
// R11 - repeat and scan bits choose among the four modes
// R12 - fixed single: convert once, then end, busy clear, interrupt
// R13 - scan single: after the last channel end, busy clear, interrupt
// R14 - software checks activity has stopped before any standby
// R15 - twenty-four read-only result registers, high and low per channel
// R16 - low register bit 0 is set whenever a new result lands
// R17 - reading either result register clears its flag and the end flag
// R18 - one channel takes 99 clock states
// R19 - fixed repeat keeps busy; interrupt every or every fourth conversion
// R20 - clearing repeat finishes the current conversion, then stops
// R21 - high holds bits 9..2; low holds bits 1..0 on top, ones below
// R22 - a start while busy restarts from the first selected channel
//
// The implementer's own choice: the AXI4-Lite slave port.
`include "adc_regs.svh"
module adc_sequencer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_trigger_input_n,
	input wire logic comp_high,
	output adc_pkg::result_t sar_trial,
	output logic [3:0] analog_channel,
	output logic reference_switch_on,
	output logic conv_done_irq
);
	sar_if link();

	sar_engine engine (
		.aclk(aclk),
		.aresetn(aresetn),
		.link(link),
		.comp_high(comp_high),
		.trial(sar_trial)
	);

	// control registers
	logic scan;
	logic repeat_on;
	logic interval;
	logic [3:0] channel_select;
	logic ext_trigger_enable;
	logic conv_end_flag;

	// sequencer state
	adc_pkg::seq_state_t state;
	logic rep_mode;
	logic [1:0] rep_cnt;
	logic trig_prev;
	logic eng_start;
	adc_pkg::result_t results [adc_pkg::num_ch];
	logic [adc_pkg::num_ch-1:0] result_stored_flag;

	// write channel capture, address and data taken in either order
	logic aw_held;
	logic w_held;
	logic [13:0] aw_idx;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire aw_now = aw_held || aw_take;
	wire w_now = w_held || w_take;
	wire wr_fire = aw_now && w_now;
	wire [13:0] wr_idx = aw_held ? aw_idx : s_axi_awaddr[15:2];
	wire [31:0] wr_data = w_held ? wdata_q : s_axi_wdata;
	wire [3:0] wr_strb = w_held ? wstrb_q : s_axi_wstrb;
	wire wr_lane0 = wr_fire && wr_strb[0];
	wire wr_main = wr_lane0 && wr_idx == `ADC_IDX_MAIN;
	wire wr_chan = wr_lane0 && wr_idx == `ADC_IDX_CHAN;
	wire wr_trig = wr_lane0 && wr_idx == `ADC_IDX_TRIG;
	wire [13:0] res_off = wr_idx - `ADC_IDX_LO_CH0;
	wire wr_res = res_off < `ADC_NUM_RES_REGS;
	wire wr_known = wr_res || wr_idx == `ADC_IDX_MAIN ||
		wr_idx == `ADC_IDX_CHAN || wr_idx == `ADC_IDX_TRIG;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_idx <= 14'h0000;
		end else if (aw_take) begin
			aw_idx <= s_axi_awaddr[15:2];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (w_take) begin
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end
	end

	// a channel taken alone waits here for its partner
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end else begin
			aw_held <= aw_now && !wr_fire;
			w_held <= w_now && !wr_fire;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read decode; result pair k sits at low index base+2k, high base+2k+1
	assign s_axi_arready = !s_axi_rvalid;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire [13:0] rd_idx = s_axi_araddr[15:2];
	wire [13:0] rd_off = rd_idx - `ADC_IDX_LO_CH0;
	wire rd_res = rd_off < `ADC_NUM_RES_REGS;
	wire [3:0] rd_ch = rd_off[4:1];
	wire rd_hi = rd_off[0];
	wire res_read = ar_take && rd_res;
	wire [adc_pkg::res_bits-1:0] rd_val = results[rd_ch];
	wire [7:0] hi_byte = rd_val[9:2];
	wire [7:0] lo_byte = {rd_val[1:0], `LOW_ONES,
		result_stored_flag[rd_ch]};
	wire [7:0] main_byte = {conv_end_flag, state == adc_pkg::st_conv,
		2'h0, interval, repeat_on, scan, 1'b0};
	wire [7:0] chan_byte = {reference_switch_on, 3'h0, channel_select};
	wire [7:0] trig_byte = {7'h00, ext_trigger_enable};
	wire rd_known = rd_res || rd_idx == `ADC_IDX_MAIN ||
		rd_idx == `ADC_IDX_CHAN || rd_idx == `ADC_IDX_TRIG;
	wire [7:0] rd_byte = rd_res ? (rd_hi ? hi_byte : lo_byte) : // [R21]
		rd_idx == `ADC_IDX_MAIN ? main_byte :
		rd_idx == `ADC_IDX_CHAN ? chan_byte :
		rd_idx == `ADC_IDX_TRIG ? trig_byte : 8'h00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// data is captured at the take, so later result stores cannot tear it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rdata <= {24'h000000, rd_byte};
			s_axi_rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	// control register writes; start bit is a trigger and reads as zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{interval, repeat_on, scan} <= `MAIN_RESET; // [R5]
		end else if (wr_main) begin
			scan <= wr_data[`MAIN_SCAN]; // [R11]
			repeat_on <= wr_data[`MAIN_REPEAT]; // [R20]
			interval <= wr_data[`MAIN_INTERVAL];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			channel_select <= `CHAN_RESET; // [R5]
		end else if (wr_chan) begin
			channel_select <= wr_data[`CHAN_SEL_LSB +: 4];
		end
	end

	// the reference switch is only a level; settling is left to software
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reference_switch_on <= `REF_RESET;
		end else if (wr_chan) begin
			reference_switch_on <= wr_data[`CHAN_REF];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_trigger_enable <= `TRIG_RESET;
		end else if (wr_trig) begin
			ext_trigger_enable <= wr_data[`TRIG_EN];
		end
	end

	// start sources; the trigger pin is taken as synchronous
	wire trig_fall = trig_prev && !ext_trigger_input_n;
	wire sw_start = wr_main && wr_data[`MAIN_START]; // [R6]
	wire start_req = sw_start || (ext_trigger_enable && trig_fall); // [R7]
	// a new main write lands with the start, so use the written mode bits
	wire start_scan = sw_start ? wr_data[`MAIN_SCAN] : scan;
	wire start_rep = sw_start ? wr_data[`MAIN_REPEAT] : repeat_on;

	// completion bookkeeping
	wire fixed_rep = rep_mode && !scan;
	wire scan_done = !scan || analog_channel >= channel_select;
	wire keep_going = rep_mode ? repeat_on : !scan_done; // [R20]
	wire [3:0] slot = fixed_rep ? {2'h0, rep_cnt} : analog_channel;
	wire store = link.done && state == adc_pkg::st_conv &&
		slot < 4'(adc_pkg::num_ch);
	wire end_event = link.done && state == adc_pkg::st_conv &&
		(fixed_rep || scan_done); // [R12] [R13]
	wire irq_event = end_event &&
		(!fixed_rep || !interval || rep_cnt == `IRQ_EVERY); // [R19]
	wire [3:0] next_channel = !scan ? channel_select :
		scan_done ? 4'h0 : analog_channel + 4'h1; // [R4]

	assign link.start = eng_start;
	wire seq_done = link.done && state == adc_pkg::st_conv;
	wire seq_next = seq_done && keep_going;
	wire seq_stop = seq_done && !keep_going;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= adc_pkg::st_idle;
		end else if (start_req) begin
			// restarting mid-sequence begins again at the first channel
			state <= adc_pkg::st_conv; // [R9] [R22]
		end else if (seq_stop) begin
			state <= adc_pkg::st_idle; // [R12] [R13] [R20]
		end
	end

	// repeat is latched at start so clearing it can only end the run
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rep_mode <= 1'b0;
		end else if (start_req) begin
			rep_mode <= start_rep;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rep_cnt <= 2'h0;
		end else if (start_req) begin
			rep_cnt <= 2'h0;
		end else if (seq_done) begin
			rep_cnt <= rep_cnt + 2'h1;
		end
	end

	// reset to the idle level so release of reset is no false edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trig_prev <= 1'b1;
		end else begin
			trig_prev <= ext_trigger_input_n;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eng_start <= 1'b0;
		end else begin
			eng_start <= start_req || seq_next; // [R19]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			analog_channel <= 4'h0;
		end else if (start_req) begin
			analog_channel <= start_scan ? 4'h0 : channel_select; // [R3]
		end else if (seq_next) begin
			analog_channel <= next_channel; // [R4]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conv_done_irq <= 1'b0;
		end else begin
			conv_done_irq <= irq_event; // [R10]
		end
	end

	// result store and the stored flags; a set beats a same-cycle clear
	genvar ch;
	generate
		for (ch = 0; ch < adc_pkg::num_ch; ch++) begin : g_ch
			wire set_flag = store && slot == 4'(ch);
			wire clr_flag = res_read && rd_ch == 4'(ch);
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					result_stored_flag[ch] <= 1'b0;
				end else begin
					result_stored_flag[ch] <= set_flag || // [R16]
						(result_stored_flag[ch] && !clr_flag); // [R17]
				end
			end
			// results keep no reset value, like the converter they model
			always_ff @(posedge aclk) begin
				if (set_flag) begin
					results[ch] <= link.result; // [R15]
				end
			end
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conv_end_flag <= 1'b0;
		end else begin
			conv_end_flag <= end_event || // [R10]
				(conv_end_flag && !res_read); // [R17]
		end
	end
endmodule

// ===== verilog/adc_regs.svh
// Purpose: register indices, field positions, reset values and timing counts
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

`define ADC_IDX_HI_CH0 14'h12a1
`define ADC_IDX_HI_CH1 14'h12a3
`define ADC_IDX_HI_CH2 14'h12a5
`define ADC_IDX_HI_CH3 14'h12a7
`define ADC_IDX_HI_CH4 14'h12a9
`define ADC_IDX_HI_CH5 14'h12ab
`define ADC_IDX_HI_CH6 14'h12ad
`define ADC_IDX_HI_CH7 14'h12af
`define ADC_IDX_HI_CH8 14'h12b1
`define ADC_IDX_HI_CH9 14'h12b3
`define ADC_IDX_HI_CH10 14'h12b5
`define ADC_IDX_HI_CH11 14'h12b7
`define ADC_IDX_LO_CH0 14'h12a0
`define ADC_NUM_RES_REGS 14'h0018
`define ADC_IDX_MAIN 14'h12b8
`define ADC_IDX_CHAN 14'h12b9
`define ADC_IDX_TRIG 14'h12ba

`define MAIN_START 0
`define MAIN_SCAN 1
`define MAIN_REPEAT 2
`define MAIN_INTERVAL 3
`define MAIN_BUSY 6
`define MAIN_END 7
`define CHAN_SEL_LSB 0
`define CHAN_REF 7
`define TRIG_EN 0

`define MAIN_RESET 3'h0
`define CHAN_RESET 4'h0
`define REF_RESET 1'h0
`define TRIG_RESET 1'h0
`define LOW_ONES 5'h1f

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define CONV_STATES 7'h63
`define STEP_STATES 4'h9
`define IRQ_EVERY 2'h3

`endif

// ===== verilog/adc_pkg.sv
// Purpose: shared types of the converter sequencer
// Assumes: nothing
// Notes: result width and channel count live here; register numbers live in adc_regs.svh
package adc_pkg;
	parameter int res_bits = 10;
	parameter int num_ch = 12;
	typedef enum logic [0:0] {
		st_idle = 1'b0,
		st_conv = 1'b1
	} seq_state_t;
	typedef logic [res_bits-1:0] result_t;
endpackage

// ===== verilog/sar_if.sv
// Purpose: carrier between sequencer and approximation engine
// Assumes: one clock
// Notes: start and done are one-cycle pulses
interface sar_if;
	logic start;
	logic done;
	adc_pkg::result_t result;
	modport seq(output start, input done, input result);
	modport eng(input start, output done, output result);
endinterface

// ===== verilog/sar_engine.sv
// Purpose: successive approximation of one sample
// Assumes: comp_high is high while the input exceeds the trial level
// Notes: a start pulse while busy restarts the approximation
`include "adc_regs.svh"
module sar_engine (
	input wire logic aclk,
	input wire logic aresetn,
	sar_if.eng link,
	input wire logic comp_high,
	output adc_pkg::result_t trial
);
	logic active;
	logic resolved;
	logic [6:0] cnt;
	logic [3:0] stc;
	logic [3:0] bitpos;
	wire last = cnt == `CONV_STATES - 7'h01;
	wire step_end = stc == `STEP_STATES - 4'h1;
	wire decide = active && step_end && !resolved;

	// one bit decided per step, the rest of the 99 states is settling margin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active <= 1'b0;
			resolved <= 1'b0;
			cnt <= 7'h00;
			stc <= 4'h0;
			bitpos <= 4'h9;
			trial <= '0;
			link.done <= 1'b0;
			link.result <= '0;
		end else begin
			link.done <= 1'b0;
			if (link.start) begin
				active <= 1'b1;
				resolved <= 1'b0;
				cnt <= 7'h00;
				stc <= 4'h0;
				bitpos <= 4'h9;
				trial <= 10'h200;
			end else if (active) begin
				cnt <= cnt + 7'h01;
				stc <= step_end ? 4'h0 : stc + 4'h1;
				if (last) begin // [R18]
					active <= 1'b0;
					link.done <= 1'b1;
					link.result <= trial;
				end
				if (decide) begin // [R1]
					trial[bitpos] <= comp_high;
					if (bitpos != 4'h0) begin
						trial[bitpos-4'h1] <= 1'b1;
						bitpos <= bitpos - 4'h1;
					end else begin
						resolved <= 1'b1;
					end
				end
			end
		end
	end
endmodule

// ===== tb/adc_sequencer_asserts.sv
// Purpose: port-level checks of the converter sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: bound onto adc_sequencer at the foot of this file
`include "adc_regs.svh"
module adc_seq_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] analog_channel,
	input wire logic reference_switch_on,
	input wire logic conv_done_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// remember whether the read in flight targets a low result byte
	logic lo_rd;
	wire logic [13:0] ridx = s_axi_araddr[15:2];
	wire logic is_lo = !ridx[0] && ridx >= `ADC_IDX_LO_CH0 &&
		ridx < `ADC_IDX_LO_CH0 + `ADC_NUM_RES_REGS;
	always_ff @(posedge aclk)
		if (s_axi_arvalid && s_axi_arready) lo_rd <= is_lo;
	AST_IRQ_PULSE: assert property (conv_done_irq |=> !conv_done_irq)
		else $error("irq pulse longer than one cycle");
	AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write response missing");
	AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid) else $error("write response repeated");
	AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read data missing");
	AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid) else $error("read data repeated");
	AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	AST_RD_TOP: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
		else $error("read data upper bits set");
	AST_LOW_ONES: assert property (s_axi_rvalid && lo_rd
		|-> s_axi_rdata[5:1] == `LOW_ONES) else $error("low byte filler wrong");
	AST_RESET_STATE: assert property ($rose(aresetn) |->
		analog_channel == 4'h0 && !reference_switch_on)
		else $error("state after reset wrong");
	cover property (conv_done_irq);
	cover property (s_axi_rvalid && lo_rd);
	cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule
bind adc_sequencer adc_seq_checker adc_seq_checker_inst (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .analog_channel, .reference_switch_on,
	.conv_done_irq);

// ===== tb/tb_sar_adc_sequencer.sv
// Purpose: self-checking bench of the converter sequencer
// Assumes: comparator model is high while the input exceeds the trial code
// Notes: bready and rready stay high, which the bus allows
`include "adc_regs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
	$display("unexpected at %0t: %h %h", $time, a, b); end end
module tb_sar_adc_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 0;
	logic aresetn = 0;
	logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic s_axi_bready = 1, s_axi_rready = 1;
	logic ext_trigger_input_n = 1, comp_high = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, reference_switch_on, conv_done_irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, d;
	logic [3:0] analog_channel;
	adc_pkg::result_t sar_trial;
	logic [9:0] vin [12];
	int error_cnt = 0, n_compared = 0, irq_cnt = 0, seed = 39, k, c;
	adc_sequencer adc_sequencer_inst (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.ext_trigger_input_n, .comp_high, .sar_trial, .analog_channel,
		.reference_switch_on, .conv_done_irq);
	always #2.5 aclk = ~aclk;
	always @(posedge aclk)
		comp_high <= vin[analog_channel] > sar_trial;
	// counted on the falling edge so the pulse is seen once, settled
	always @(negedge aclk)
		if (conv_done_irq === 1'b1) irq_cnt++;
	function logic [9:0] ex(input logic [9:0] v);
		return v == 0 ? 10'h0 : v - 10'h1;
	endfunction
	function logic [7:0] lo(input logic [9:0] e, input logic f);
		return {e[1:0], 5'h1f, f};
	endfunction
	task tally_and_finish;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task tmo;
		error_cnt++;
		tally_and_finish;
	endtask
	task wr(input logic [13:0] i, input logic [7:0] v);
		int n;
		bit ta, tw, tb;
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		for (n = 0; n < 20; n++) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
			if (tb) break;
		end
		if (n == 20) tmo;
	endtask
	task rd(input logic [13:0] i);
		int n;
		bit ta, tb;
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1;
		for (n = 0; n < 20; n++) begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tb = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 0;
			if (tb) break;
		end
		if (n == 20) tmo;
	endtask
	task rc(input logic [13:0] i, input logic [7:0] e);
		rd(i);
		`CHK(d, {24'h0, e})
	endtask
	task wait_irq(input int t);
		int n;
		for (n = 0; n < 5000 && irq_cnt < t; n++) @(posedge aclk);
		if (n == 5000) tmo;
	endtask
	initial begin
		for (k = 0; k < 12; k++) vin[k] = 10'($random(seed));
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		rc(`ADC_IDX_MAIN, 8'h00);
		rc(`ADC_IDX_CHAN, 8'h00);
		rc(`ADC_IDX_TRIG, 8'h00);
		rd(14'h0001);
		`CHK(r, `RESP_SLVERR)
		wr(`ADC_IDX_HI_CH0, 8'h5a);
		`CHK(r, `RESP_OKAY)
		c = $unsigned($random(seed)) % 11;
		wr(`ADC_IDX_CHAN, 8'h80 | 8'(c));
		// reference settles 3 us before the first start
		repeat (600) @(posedge aclk);
		wr(`ADC_IDX_MAIN, 8'h01);
		rc(`ADC_IDX_MAIN, 8'h40);
		`CHK(analog_channel, 4'(c))
		`CHK(reference_switch_on, 1'b1)
		wait_irq(1);
		rc(`ADC_IDX_MAIN, 8'h80);
		rc(14'(`ADC_IDX_LO_CH0 + 2 * c), lo(ex(vin[c]), 1));
		rc(14'(`ADC_IDX_LO_CH0 + 2 * c + 1), 8'(ex(vin[c]) >> 2));
		rc(14'(`ADC_IDX_LO_CH0 + 2 * c), lo(ex(vin[c]), 0));
		rc(`ADC_IDX_MAIN, 8'h00);
		wr(`ADC_IDX_CHAN, 8'h82);
		wr(`ADC_IDX_MAIN, 8'h03);
		repeat (110) @(posedge aclk);
		`CHK(irq_cnt, 1)
		wait_irq(2);
		rc(`ADC_IDX_MAIN, 8'h82);
		for (k = 0; k < 3; k++)
			rc(14'(`ADC_IDX_LO_CH0 + 2 * k), lo(ex(vin[k]), 1));
		wr(`ADC_IDX_CHAN, 8'h85);
		wr(`ADC_IDX_MAIN, 8'h0d);
		wait_irq(3);
		rc(`ADC_IDX_MAIN, 8'hcc);
		for (k = 0; k < 4; k++)
			rc(14'(`ADC_IDX_LO_CH0 + 2 * k), lo(ex(vin[5]), 1));
		repeat (300) @(posedge aclk);
		`CHK(irq_cnt, 3)
		wr(`ADC_IDX_MAIN, 8'h00);
		repeat (110) @(posedge aclk);
		rd(`ADC_IDX_MAIN);
		`CHK(d[6], 1'b0)
		wr(`ADC_IDX_CHAN, 8'h81);
		wr(`ADC_IDX_MAIN, 8'h07);
		k = irq_cnt;
		wait_irq(k + 1);
		rd(`ADC_IDX_MAIN);
		`CHK(d[6], 1'b1)
		wr(`ADC_IDX_MAIN, 8'h00);
		repeat (110) @(posedge aclk);
		wr(`ADC_IDX_TRIG, 8'h01);
		// select stays off 1011 while the trigger pin is in use
		wr(`ADC_IDX_CHAN, 8'h84);
		k = irq_cnt;
		ext_trigger_input_n <= 0;
		wait_irq(k + 1);
		rc(14'(`ADC_IDX_LO_CH0 + 8), lo(ex(vin[4]), 1));
		ext_trigger_input_n <= 1;
		wr(`ADC_IDX_TRIG, 8'h00);
		ext_trigger_input_n <= 0;
		repeat (110) @(posedge aclk);
		`CHK(irq_cnt, k + 1)
		// software confirms the converter is idle before any standby
		rd(`ADC_IDX_MAIN);
		`CHK(d[6], 1'b0)
		tally_and_finish;
	end
endmodule
